// ---- logic/fos_regs.vh ----
// constants of the flow output scaler: register map, fields, resets, timing
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`ifndef FOS_REGS_VH
`define FOS_REGS_VH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define FOS_OFF_CTRL      8'h00
`define FOS_OFF_LOW       8'h04
`define FOS_OFF_HIGH      8'h08
`define FOS_OFF_ADDR      8'h0C
`define FOS_OFF_MENU      8'h10
`define FOS_OFF_STATUS    8'h14
`define FOS_OFF_ACTIVE    8'h18
`define FOS_OFF_TOTAL     8'h1C
`define FOS_OFF_RATE      8'h20

// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define FOS_CTRL_EN_BIT   0
`define FOS_CTRL_MUL_LSB  1
`define FOS_CTRL_MUL_MSB  3
`define FOS_CTRL_DP_LSB   4
`define FOS_CTRL_DP_MSB   6
`define FOS_DP_MAX        3'h4
`define FOS_MENU_ADV_BIT  0
`define FOS_MENU_OPEN_BIT 1
`define FOS_ADDR_CLR_BIT  4
`define FOS_ADDR_MAX      8'hFF
`define FOS_RST_CTRL      7'h00
`define FOS_RST_LOW       32'h0000_0000
`define FOS_RST_HIGH      32'h0000_03E8
`define FOS_RST_ADDR      8'h01
`define FOS_DAC_TOP       16'hFFFF
`define FOS_TOTAL_WRAP    27'h5F5_E0FF

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define FOS_CLK_PERIOD_NS   10
`define FOS_PULSE_MIN_PER_NS 10000000
`define FOS_PULSE_MAX_HI_NS  1000000000

`endif

// ---- logic/fos_top.v ----
// flow output scaler: loop converter code, scaled pulse output, settings
// assumes rate and total_tick come from logic on aclk, AXI4-Lite master
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "fos_regs.vh"

module fos_top #(
  parameter [31:0] MIN_PERIOD = `FOS_PULSE_MIN_PER_NS / `FOS_CLK_PERIOD_NS,
  parameter [31:0] MAX_HIGH   = `FOS_PULSE_MAX_HI_NS / `FOS_CLK_PERIOD_NS
)(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] flow_rate,
  input  wire        total_tick,
  output reg  [15:0] dac_code,
  output reg         loop_en_out,
  output reg         pulse_out
);
  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_EN   = 3'h1;
  localparam [2:0] M_LOW  = 3'h2;
  localparam [2:0] M_HIGH = 3'h3;
  localparam [2:0] M_MUL  = 3'h4;
  localparam [2:0] M_ADDR = 3'h5;
  // multiplier select to increment count; 0 means pulses off
  function [16:0] mul_count;
    input [2:0] sel;
    begin
      case (sel)
        3'h1:    mul_count = 17'h00001;
        3'h2:    mul_count = 17'h0000A;
        3'h3:    mul_count = 17'h00064;
        3'h4:    mul_count = 17'h003E8;
        3'h5:    mul_count = 17'h02710;
        3'h6:    mul_count = 17'h186A0;
        default: mul_count = 17'h00000;
      endcase
    end
  endfunction
  // ---------------------------------------------------------------------
  // settings: staged copies written through the registers and committed by the menu, active copies used
  // ---------------------------------------------------------------------
  reg  [6:0]  stg_ctrl_r;
  reg  [31:0] stg_low_r;
  reg  [31:0] stg_high_r;
  reg  [7:0]  stg_addr_r;
  reg         act_en_r;
  reg  [2:0]  act_mul_r;
  reg  [31:0] act_low_r;
  reg  [31:0] act_high_r;
  reg  [7:0]  act_addr_r;
  reg  [2:0]  step_r;
  reg  [26:0] total_r;
  // ---------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire        wr_full = (w_strb_r == 4'hF);
  wire        wr_ok   = (aw_addr_r <= `FOS_OFF_RATE) & (aw_addr_r[1:0] == 2'b00);
  wire        rd_ok   = (s_axi_araddr <= `FOS_OFF_RATE) & (s_axi_araddr[1:0] == 2'b00);
  // byte lanes other than all-four are ignored: the LOW and HIGH fields span lanes
  wire        do_wr   = wr_go & wr_ok & wr_full;
  wire [11:0] addr_x10 = {4'h0, stg_addr_r} * 12'h00A;
  wire [11:0] addr_sum = addr_x10 + {8'h00, w_data_r[3:0]};
  reg  [31:0] rd_mux;
  always @*
  begin
    case (s_axi_araddr)
      `FOS_OFF_CTRL:   rd_mux = {25'h0, stg_ctrl_r};
      `FOS_OFF_LOW:    rd_mux = stg_low_r;
      `FOS_OFF_HIGH:   rd_mux = stg_high_r;
      `FOS_OFF_ADDR:   rd_mux = {24'h0, stg_addr_r};
      `FOS_OFF_MENU:   rd_mux = {29'h0, step_r};
      `FOS_OFF_STATUS: rd_mux = {dac_code, 14'h0, pulse_out, loop_en_out};
      `FOS_OFF_ACTIVE: rd_mux = {act_addr_r, 20'h0, act_mul_r, act_en_r};
      `FOS_OFF_TOTAL:  rd_mux = {5'h00, total_r};
      `FOS_OFF_RATE:   rd_mux = flow_rate;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_rvalid & s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // settings menu and commit
  // ---------------------------------------------------------------------
  wire menu_wr = do_wr & (aw_addr_r == `FOS_OFF_MENU);
  wire adv     = menu_wr & w_data_r[`FOS_MENU_ADV_BIT];
  wire opn     = menu_wr & w_data_r[`FOS_MENU_OPEN_BIT];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stg_ctrl_r <= `FOS_RST_CTRL;
      stg_low_r  <= `FOS_RST_LOW;
      stg_high_r <= `FOS_RST_HIGH;
      stg_addr_r <= `FOS_RST_ADDR;
      act_en_r   <= 1'b0;
      act_mul_r  <= 3'h0;
      act_low_r  <= `FOS_RST_LOW;
      act_high_r <= `FOS_RST_HIGH;
      act_addr_r <= `FOS_RST_ADDR;
      step_r     <= M_IDLE;
    end
    else
    begin
      if (do_wr & (aw_addr_r == `FOS_OFF_CTRL))
      begin
        stg_ctrl_r[3:0] <= (w_data_r[3:1] > 3'h6) ? {3'h6, w_data_r[0]} : w_data_r[3:0];
        stg_ctrl_r[6:4] <= (w_data_r[6:4] > `FOS_DP_MAX) ? `FOS_DP_MAX : w_data_r[6:4];
      end
      if (do_wr & (aw_addr_r == `FOS_OFF_LOW))
        stg_low_r <= w_data_r;
      if (do_wr & (aw_addr_r == `FOS_OFF_HIGH))
        stg_high_r <= w_data_r;
      if (do_wr & (aw_addr_r == `FOS_OFF_ADDR))
      begin
        if (w_data_r[`FOS_ADDR_CLR_BIT])
          stg_addr_r <= 8'h00;
        else if (w_data_r[3:0] <= 4'h9)
          stg_addr_r <= (addr_sum > 12'h0FF) ? `FOS_ADDR_MAX : addr_sum[7:0];
      end
      if (opn)
        step_r <= M_EN;
      else if (adv)
      begin
        case (step_r)
          M_EN:    step_r <= stg_ctrl_r[`FOS_CTRL_EN_BIT] ? M_LOW : M_MUL;
          M_LOW:   step_r <= M_HIGH;
          M_HIGH:  step_r <= M_MUL;
          M_MUL:
          begin
            act_en_r   <= stg_ctrl_r[`FOS_CTRL_EN_BIT];
            act_mul_r  <= stg_ctrl_r[3:1];
            act_low_r  <= stg_low_r;
            act_high_r <= stg_high_r;
            step_r     <= M_ADDR;
          end
          M_ADDR:
          begin
            act_addr_r <= stg_addr_r;
            step_r     <= M_IDLE;
          end
          default: step_r <= M_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // loop output scaling: code = (rate-low) * FFFF / (high-low)
  // ---------------------------------------------------------------------
  reg  [4:0]  div_cnt_r;
  reg  [32:0] rem_r;
  reg  [15:0] sh_r;
  reg  [15:0] quo_r;
  wire [31:0] span    = act_high_r - act_low_r;
  wire [31:0] diff    = flow_rate - act_low_r;
  wire [47:0] numer   = diff * `FOS_DAC_TOP;
  wire [32:0] rem_sh  = {rem_r[31:0], sh_r[15]};
  wire        rem_ge  = (rem_sh >= {1'b0, span});
  // a new rate waits up to 17 cycles for the next division, and its code follows 16 cycles after it is sampled
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_r   <= 5'h00;
      rem_r       <= 33'h0;
      sh_r        <= 16'h0000;
      quo_r       <= 16'h0000;
      dac_code    <= 16'h0000;
      loop_en_out <= 1'b0;
    end
    else
    begin
      loop_en_out <= act_en_r;
      if (div_cnt_r == 5'h00)
      begin
        if (!act_en_r)
          dac_code <= 16'h0000;
        else if (flow_rate <= act_low_r)
          dac_code <= 16'h0000;
        else if (flow_rate >= act_high_r)
          dac_code <= `FOS_DAC_TOP;
        else
        begin
          rem_r     <= {1'b0, numer[47:16]};
          sh_r      <= numer[15:0];
          div_cnt_r <= 5'h10;
        end
      end
      else
      begin
        rem_r     <= rem_ge ? (rem_sh - {1'b0, span}) : rem_sh;
        sh_r      <= {sh_r[14:0], 1'b0};
        quo_r     <= {quo_r[14:0], rem_ge};
        div_cnt_r <= div_cnt_r - 5'h01;
        if (!act_en_r)
          dac_code <= 16'h0000;
        else if (div_cnt_r == 5'h01)
          dac_code <= {quo_r[14:0], rem_ge};
      end
    end
  end

  // ---------------------------------------------------------------------
  // pulse output
  // ---------------------------------------------------------------------
  reg  [16:0] tick_cnt_r;
  reg  [7:0]  pend_r;
  reg  [31:0] per_cnt_r;
  reg  [31:0] hi_cnt_r;
  reg  [31:0] width_r;
  wire [16:0] mcount  = mul_count(act_mul_r);
  wire        mul_on  = (mcount != 17'h00000);
  wire        tick_ok = total_tick & mul_on;
  wire        fire    = tick_ok & (tick_cnt_r + 17'h00001 >= mcount);
  wire        start   = ~pulse_out & (pend_r != 8'h00) & (per_cnt_r >= MIN_PERIOD)
                        & (per_cnt_r >= {width_r[30:0], 1'b0});
  wire [31:0] half    = {1'b0, per_cnt_r[31:1]};
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      total_r    <= 27'h0;
      tick_cnt_r <= 17'h00000;
      pend_r     <= 8'h00;
      per_cnt_r  <= 32'h0000_0000;
      hi_cnt_r   <= 32'h0000_0000;
      width_r    <= 32'h0000_0000;
      pulse_out  <= 1'b0;
    end
    else
    begin
      if (total_tick)
        total_r <= (total_r == `FOS_TOTAL_WRAP) ? 27'h0 : total_r + 27'h1;
      if (!mul_on)
        tick_cnt_r <= 17'h00000;
      else if (tick_ok)
        tick_cnt_r <= fire ? 17'h00000 : tick_cnt_r + 17'h00001;
      // backlog saturates: a burst beyond 255 pulses is lost, never invented
      if (!mul_on)
        pend_r <= 8'h00;
      else if (fire & ~start & (pend_r != 8'hFF))
        pend_r <= pend_r + 8'h01;
      else if (~fire & start)
        pend_r <= pend_r - 8'h01;
      if (start)
        per_cnt_r <= 32'h0000_0001;
      else if (per_cnt_r != 32'hFFFF_FFFF)
        per_cnt_r <= per_cnt_r + 32'h0000_0001;
      if (start)
      begin
        pulse_out <= 1'b1;
        width_r   <= (half > MAX_HIGH) ? MAX_HIGH : half;
        hi_cnt_r  <= 32'h0000_0001;
      end
      else if (pulse_out)
      begin
        hi_cnt_r <= hi_cnt_r + 32'h0000_0001;
        if (hi_cnt_r >= width_r)
          pulse_out <= 1'b0;
      end
    end
  end
endmodule // fos_top

// ---- dv/fos_checker.sv ----
// checker for the flow output scaler: bus handshakes, loop and pulse timing
// bound into fos_top, sees only its ports
`timescale 1ns/1ps
module fos_checker #(
  parameter [31:0] MIN_PERIOD = 32'h14,
  parameter [31:0] MAX_HIGH   = 32'h32
)(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        total_tick,
  input logic [15:0] dac_code,
  input logic        loop_en_out,
  input logic        pulse_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic        pq, seen;
  logic [31:0] gap, hi, hl, tk, pc;
  wire         rise = pulse_out && !pq;
  // gap, tk and pc restart with reset and pq clears, so a pulse cut by reset is not judged
  always_ff @(posedge aclk)
  begin
    pq   <= pulse_out && aresetn;
    seen <= aresetn && (seen || rise);
    gap  <= (rise || !aresetn) ? 32'h1 : gap + 32'h1;
    hi   <= rise ? 32'h1 : hi + {31'h0, pulse_out};
    hl   <= (pq && !pulse_out) ? hi : hl;
    tk   <= aresetn ? tk + {31'h0, total_tick} : 32'h0;
    pc   <= aresetn ? pc + {31'h0, rise} : 32'h0;
  end
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bdone;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_idle_reset: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid) else $error("bus not idle");
  a_b_follows: assert property (s_wtake |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("no write response");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_ready_back: assert property (s_bdone |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("no read answer");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_loop_off_zero: assert property (!loop_en_out [*8] |-> dac_code == 16'h0)
    else $error("loop code while disabled");
  a_pulse_space: assert property (rise && seen |-> gap >= MIN_PERIOD
    && gap >= {hl[30:0], 1'b0}) else $error("pulse too soon");
  a_width_cap: assert property (pq && !pulse_out |-> hi <= MAX_HIGH)
    else $error("pulse too wide");
  a_no_early: assert property (pc <= tk)
    else $error("pulse without volume");
endmodule // fos_checker

bind fos_top fos_checker #(.MIN_PERIOD(MIN_PERIOD), .MAX_HIGH(MAX_HIGH)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .total_tick(total_tick), .dac_code(dac_code),
  .loop_en_out(loop_en_out), .pulse_out(pulse_out));

// ---- dv/fos_rtu_model.sv ----
// receiver model: counts scaled pulses and turns the loop code into current
// assumes one clock shared with the scaler
`timescale 1ns/1ps
module fos_rtu_model (
  input  logic        aclk,
  input  logic        pulse_out,
  input  logic        loop_en_out,
  input  logic [15:0] dac_code,
  output logic [31:0] pulse_cnt,
  output logic [31:0] min_gap,
  output logic [31:0] loop_ua
);
  logic        pq = 1'b0;
  logic [31:0] gap = 32'h0;
  // open loop draws no current; 4 mA at code 0, 20 mA at full scale
  assign loop_ua = loop_en_out ? 32'hFA0 + ({16'h0, dac_code} * 32'h3E80) / 32'hFFFF : 32'h0;
  initial pulse_cnt = 32'h0;
  initial min_gap = 32'hFFFF_FFFF;
  always @(posedge aclk)
  begin
    pq <= pulse_out;
    gap <= (pulse_out && !pq) ? 32'h1 : gap + 32'h1;
    if (pulse_out && !pq)
      pulse_cnt <= pulse_cnt + 32'h1;
    if (pulse_out && !pq && pulse_cnt != 32'h0 && gap < min_gap)
      min_gap <= gap;
  end
endmodule // fos_rtu_model

// ---- dv/flow_output_scaler_bench.sv ----
// bench for the flow output scaler: register tasks, loop and pulse scenarios
// assumes fos_top with short pulse timing and the receiver model
`timescale 1ns/1ps
`include "fos_regs.vh"
module flow_output_scaler_bench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, flow_rate = 32'h0, pc0 = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, total_tick = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        loop_en_out, pulse_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pulse_cnt, min_gap, loop_ua;
  logic [15:0] dac_code;
  integer      errors = 0, tests_run = 0, i;

  fos_top #(.MIN_PERIOD(32'h14), .MAX_HIGH(32'h32)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .flow_rate(flow_rate), .total_tick(total_tick), .dac_code(dac_code),
    .loop_en_out(loop_en_out), .pulse_out(pulse_out));
  fos_rtu_model u_rtu (.aclk(aclk), .pulse_out(pulse_out), .loop_en_out(loop_en_out),
    .dac_code(dac_code), .pulse_cnt(pulse_cnt), .min_gap(min_gap), .loop_ua(loop_ua));

  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  // bready waits for bvalid so the slave must hold its answer
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    integer n;
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    while (!(s_axi_bvalid && s_axi_bready) && n < 99)
    begin
      @(posedge aclk);
      n = n + 1;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready)
        s_axi_bready <= 1'b1;
    end
    chk({29'h0, (n >= 99), s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    integer n;
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    while (!(s_axi_rvalid && s_axi_rready) && n < 99)
    begin
      @(posedge aclk);
      n = n + 1;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready)
        s_axi_rready <= 1'b1;
    end
    chk(s_axi_rdata, e);
    chk({29'h0, (n >= 99), s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  end
  endtask
  // stage control, then walk the whole menu so every setting commits
  task cfg(input [6:0] c);
  begin
    wr(`FOS_OFF_CTRL, {25'h0, c}, 4'hF, 2'h0);
    wr(`FOS_OFF_MENU, 32'h2, 4'hF, 2'h0);
    repeat (c[0] ? 5 : 3) wr(`FOS_OFF_MENU, 32'h1, 4'hF, 2'h0);
  end
  endtask
  task lp(input [31:0] r, input [15:0] e, input [31:0] u);
  begin
    @(posedge aclk);
    flow_rate <= r;
    repeat (40) @(posedge aclk);
    chk({16'h0, dac_code}, {16'h0, e});
    chk(loop_ua, u);
  end
  endtask
  task ticks(input integer k, input [31:0] e);
  begin
    repeat (k)
    begin
      @(posedge aclk);
      total_tick <= 1'b1;
      @(posedge aclk);
      total_tick <= 1'b0;
    end
    repeat (600) @(posedge aclk);
    chk(pulse_cnt - pc0, e);
    pc0 = pulse_cnt;
  end
  endtask
  task conclude;
  begin
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FOS_OFF_CTRL, 32'h0, 2'h0);
    rd(`FOS_OFF_LOW, 32'h0, 2'h0);
    rd(`FOS_OFF_HIGH, 32'h3E8, 2'h0);
    rd(`FOS_OFF_ADDR, 32'h1, 2'h0);
    rd(`FOS_OFF_MENU, 32'h0, 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    rd(8'h06, 32'h0, 2'h2);
    wr(8'h24, 32'h5, 4'hF, 2'h2);
    wr(`FOS_OFF_LOW, 32'h64, 4'h3, 2'h0);
    rd(`FOS_OFF_LOW, 32'h0, 2'h0);
    wr(`FOS_OFF_LOW, 32'h64, 4'hF, 2'h0);
    wr(`FOS_OFF_HIGH, 32'h44C, 4'hF, 2'h0);
    wr(`FOS_OFF_CTRL, 32'h2, 4'hF, 2'h0);
    wr(`FOS_OFF_MENU, 32'h2, 4'hF, 2'h0);
    rd(`FOS_OFF_MENU, 32'h1, 2'h0);
    wr(`FOS_OFF_MENU, 32'h1, 4'hF, 2'h0);
    rd(`FOS_OFF_MENU, 32'h4, 2'h0);
    wr(`FOS_OFF_MENU, 32'h1, 4'hF, 2'h0);
    rd(`FOS_OFF_ACTIVE, 32'h0100_0002, 2'h0);
    wr(`FOS_OFF_ADDR, 32'h10, 4'hF, 2'h0);
    for (i = 0; i < 4; i = i + 1)
      wr(`FOS_OFF_ADDR, (i == 2) ? 32'hA : {30'h0, i[1:0]} + 32'h1 + {31'h0, i == 3}, 4'hF, 2'h0);
    wr(`FOS_OFF_MENU, 32'h1, 4'hF, 2'h0);
    rd(`FOS_OFF_ACTIVE, 32'h7D00_0002, 2'h0);
    wr(`FOS_OFF_ADDR, 32'h9, 4'hF, 2'h0);
    rd(`FOS_OFF_ADDR, 32'hFF, 2'h0);
    lp(32'h7D0, 16'h0, 32'h0);
    cfg(7'h03);
    chk({31'h0, loop_en_out}, 32'h1);
    lp(32'h32, 16'h0, 32'hFA0);
    lp(32'h64, 16'h0, 32'hFA0);
    lp(32'h258, 16'h7FFF, 32'h2EDF);
    lp(32'h44C, 16'hFFFF, 32'h4E20);
    lp(32'h7D0, 16'hFFFF, 32'h4E20);
    pc0 = pulse_cnt;
    ticks(3, 32'h3);
    chk({31'h0, min_gap >= 32'h14}, 32'h1);
    ticks(0, 32'h0);
    cfg(7'h01);
    ticks(5, 32'h0);
    cfg(7'h05);
    ticks(25, 32'h2);
    for (i = 1; i < 8; i = i + 1)
    begin
      cfg({3'h0, i[2:0], 1'b1});
      rd(`FOS_OFF_ACTIVE, {8'hFF, 20'h0, ((i > 6) ? 3'h6 : i[2:0]), 1'b1}, 2'h0);
    end
    rd(`FOS_OFF_STATUS, 32'hFFFF_0001, 2'h0);
    rd(`FOS_OFF_RATE, 32'h7D0, 2'h0);
    rd(`FOS_OFF_TOTAL, 32'h21, 2'h0);
    wr(`FOS_OFF_CTRL, 32'h7F, 4'hF, 2'h0);
    rd(`FOS_OFF_CTRL, 32'h4D, 2'h0);
    cfg(7'h02);
    lp(32'h258, 16'h0, 32'h0);
    conclude;
  end
  initial
  begin
    #400000;
    errors = errors + 1;
    conclude;
  end
endmodule // flow_output_scaler_bench
